// ==== rtl/fscr_consts.vh ====
`ifndef FSCR_CONSTS_VH
`define FSCR_CONSTS_VH
// ---------------------------------------------------------------
// register pointers (low 8 bits of internal address)
// ---------------------------------------------------------------
`define FSCR_ADDR_CTRL 8'h07
`define FSCR_ADDR_HIGH_SPEED_DIVIDER_LO 8'h17
`define FSCR_ADDR_DIVSEL 8'h18
`define FSCR_ADDR_FB0 8'h1a
`define FSCR_ADDR_FB5 8'h1f
`define FSCR_ADDR_KV 8'h20
`define FSCR_ADDR_FSGAIN 8'h23
`define FSCR_ADDR_CALOVR 8'h45
`define FSCR_ADDR_OFS0 8'he7
`define FSCR_ADDR_OFS1 8'he8
`define FSCR_ADDR_OFS2 8'he9
`define FSCR_ADDR_PAGE 8'hff
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FSCR_POW2_LSB 4
`define FSCR_POW2_MSB 6
`define FSCR_CALSTART_BIT 3
`define FSCR_CALOVR_BIT 7
`define FSCR_FB_INT_LSB 32
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FSCR_RST_HIGH_SPEED_DIVIDER_LO 8'h54
`define FSCR_RST_FB_WORD 43'h064_0000_0000
`define FSCR_RST_KV 5'h06
`define FSCR_RST_FSGAIN 8'h80
`define FSCR_RST_CALOVR 8'h01
// ---------------------------------------------------------------
// gain scale: kv ppm/V times two = field times fifteen
// ---------------------------------------------------------------
`define FSCR_KV_X2_MULT 4'hf
`endif

// ==== rtl/fscr_pow2_decode.v ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// power-of-two divider decode
// ---------------------------------------------------------------
module fscr_pow2_decode (
  input wire [2:0] code,
  output reg [5:0] ratio,
  output reg bypass
);
  // codes beyond five saturate at divide by 32
  always @* begin
    bypass = (code == 3'h0);
    case (code)
      3'h0: ratio = 6'h01;
      3'h1: ratio = 6'h02;
      3'h2: ratio = 6'h04;
      3'h3: ratio = 6'h08;
      3'h4: ratio = 6'h10;
      default: ratio = 6'h20;
    endcase
  end
endmodule

// ==== rtl/fscr_regs.v ====
`timescale 1ns/10ps
`include "fscr_consts.vh"
module fscr_regs (
  input wire CORE_CLK,
  input wire RESETN,
  input wire WR_STB,
  input wire RD_STB,
  input wire [7:0] REG_PTR,
  input wire [7:0] WR_DATA,
  output reg [7:0] RD_DATA,
  output reg RD_VALID,
  output reg [9:0] INT_ADDR,
  output reg [2:0] POW2_CODE,
  output reg [5:0] POW2_RATIO,
  output reg POW2_BYPASS,
  output reg [10:0] FB_INT,
  output reg [31:0] FB_FRAC,
  output reg [10:0] HIGH_SPEED_DIVIDER_WORD,
  output reg [8:0] KV_X2_PPM,
  output reg [7:0] FULL_SCALE_GAIN,
  output reg CAL_ALLOWED,
  output reg CAL_START,
  output reg signed [23:0] FINE_OFFSET
);
  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  reg [1:0] page_r; // bank select
  reg [7:0] high_speed_divider_lo_r; // high speed divider low byte
  reg [7:0] divsel_r; // pow2 field and divider top bits
  reg [42:0] fb_r; // feedback divide word
  reg [4:0] kv_r; // tuning gain field
  reg [7:0] fsgain_r; // full scale gain
  reg [7:0] calovr_r; // override register
  reg [7:0] ofs0_r; // staged low byte
  reg [7:0] ofs1_r; // staged middle byte
  reg [23:0] ofs_r; // active offset
  reg cal_pulse_r; // one-cycle calibration request
  wire [9:0] addr_w;
  wire page0_w;
  wire [5:0] ratio_w;
  wire bypass_w;
  wire [8:0] kv_x2_w;

  // -------------------------------------------------------------
  // address formation
  // -------------------------------------------------------------
  assign addr_w = {page_r, REG_PTR};
  // page register itself is reachable from every page
  assign page0_w = (page_r == 2'h0);
  // gain in half-ppm units keeps the 7.5 factor exact
  assign kv_x2_w = kv_r * {5'h00, `FSCR_KV_X2_MULT};

  // hit test shared by read and write decode
  function hit;
    input [7:0] ptr;
    input [7:0] target;
    input p0;
    begin
      hit = (ptr == target) && (p0 || target == `FSCR_ADDR_PAGE);
    end
  endfunction

  fscr_pow2_decode u_dec (
    .code(divsel_r[`FSCR_POW2_MSB:`FSCR_POW2_LSB]),
    .ratio(ratio_w),
    .bypass(bypass_w)
  );

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      page_r <= 2'h0;
      high_speed_divider_lo_r <= `FSCR_RST_HIGH_SPEED_DIVIDER_LO;
      divsel_r <= 8'h00;
      fb_r <= `FSCR_RST_FB_WORD;
      kv_r <= `FSCR_RST_KV;
      fsgain_r <= `FSCR_RST_FSGAIN;
      calovr_r <= `FSCR_RST_CALOVR;
      ofs0_r <= 8'h00;
      ofs1_r <= 8'h00;
      ofs_r <= 24'h000000;
      cal_pulse_r <= 1'b0;
    end else begin
      // calibration request lasts one cycle only
      cal_pulse_r <= 1'b0;
      if (WR_STB) begin
        if (hit(REG_PTR, `FSCR_ADDR_PAGE, page0_w))
          page_r <= WR_DATA[1:0];
        if (hit(REG_PTR, `FSCR_ADDR_CTRL, page0_w))
          cal_pulse_r <= WR_DATA[`FSCR_CALSTART_BIT];
        if (hit(REG_PTR, `FSCR_ADDR_HIGH_SPEED_DIVIDER_LO, page0_w))
          high_speed_divider_lo_r <= WR_DATA;
        if (hit(REG_PTR, `FSCR_ADDR_DIVSEL, page0_w))
          divsel_r <= WR_DATA & 8'h77; // unused bits stay zero
        // feedback bytes 26..31, last one only three bits
        if (page0_w && REG_PTR >= `FSCR_ADDR_FB0 && REG_PTR <= `FSCR_ADDR_FB5) begin
          case (REG_PTR[2:0])
            3'h2: fb_r[7:0] <= WR_DATA;
            3'h3: fb_r[15:8] <= WR_DATA;
            3'h4: fb_r[23:16] <= WR_DATA;
            3'h5: fb_r[31:24] <= WR_DATA;
            3'h6: fb_r[39:32] <= WR_DATA;
            default: fb_r[42:40] <= WR_DATA[2:0];
          endcase
        end
        if (hit(REG_PTR, `FSCR_ADDR_KV, page0_w))
          kv_r <= WR_DATA[4:0];
        if (hit(REG_PTR, `FSCR_ADDR_FSGAIN, page0_w))
          fsgain_r <= WR_DATA;
        if (hit(REG_PTR, `FSCR_ADDR_CALOVR, page0_w))
          calovr_r <= WR_DATA;
        // low bytes only stage, active word untouched
        if (hit(REG_PTR, `FSCR_ADDR_OFS0, page0_w))
          ofs0_r <= WR_DATA;
        if (hit(REG_PTR, `FSCR_ADDR_OFS1, page0_w))
          ofs1_r <= WR_DATA;
        // top byte commits all three together
        if (hit(REG_PTR, `FSCR_ADDR_OFS2, page0_w))
          ofs_r <= {WR_DATA, ofs1_r, ofs0_r};
      end
    end
  end

  // -------------------------------------------------------------
  // read mux; unmapped pointers read zero
  // -------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_STB;
      if (RD_STB) begin
        if (hit(REG_PTR, `FSCR_ADDR_PAGE, page0_w))
          RD_DATA <= {6'h00, page_r};
        else if (!page0_w)
          RD_DATA <= 8'h00; // other pages hold nothing here
        else begin
          case (REG_PTR)
            `FSCR_ADDR_CTRL: RD_DATA <= 8'h00; // start bit reads back cleared
            `FSCR_ADDR_HIGH_SPEED_DIVIDER_LO: RD_DATA <= high_speed_divider_lo_r;
            `FSCR_ADDR_DIVSEL: RD_DATA <= divsel_r;
            8'h1a: RD_DATA <= fb_r[7:0];
            8'h1b: RD_DATA <= fb_r[15:8];
            8'h1c: RD_DATA <= fb_r[23:16];
            8'h1d: RD_DATA <= fb_r[31:24];
            8'h1e: RD_DATA <= fb_r[39:32];
            `FSCR_ADDR_FB5: RD_DATA <= {5'h00, fb_r[42:40]};
            `FSCR_ADDR_KV: RD_DATA <= {3'h0, kv_r};
            `FSCR_ADDR_FSGAIN: RD_DATA <= fsgain_r;
            `FSCR_ADDR_CALOVR: RD_DATA <= calovr_r;
            // staged bytes read back what was written
            `FSCR_ADDR_OFS0: RD_DATA <= ofs0_r;
            `FSCR_ADDR_OFS1: RD_DATA <= ofs1_r;
            `FSCR_ADDR_OFS2: RD_DATA <= ofs_r[23:16];
            default: RD_DATA <= 8'h00;
          endcase
        end
      end
    end
  end

  // -------------------------------------------------------------
  // registered outputs to the synthesis core
  // -------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      INT_ADDR <= 10'h000;
      POW2_CODE <= 3'h0;
      POW2_RATIO <= 6'h01;
      POW2_BYPASS <= 1'b1;
      FB_INT <= 11'h064;
      FB_FRAC <= 32'h00000000;
      HIGH_SPEED_DIVIDER_WORD <= 11'h054;
      KV_X2_PPM <= 9'h05a;
      FULL_SCALE_GAIN <= `FSCR_RST_FSGAIN;
      CAL_ALLOWED <= 1'b0;
      CAL_START <= 1'b0;
      FINE_OFFSET <= 24'sh000000;
    end else begin
      INT_ADDR <= addr_w;
      POW2_CODE <= divsel_r[`FSCR_POW2_MSB:`FSCR_POW2_LSB];
      POW2_RATIO <= ratio_w;
      POW2_BYPASS <= bypass_w;
      FB_INT <= fb_r[42:`FSCR_FB_INT_LSB];
      FB_FRAC <= fb_r[31:0];
      HIGH_SPEED_DIVIDER_WORD <= {divsel_r[2:0], high_speed_divider_lo_r};
      KV_X2_PPM <= kv_x2_w;
      FULL_SCALE_GAIN <= fsgain_r;
      CAL_ALLOWED <= ~calovr_r[`FSCR_CALOVR_BIT];
      // a start request is dropped while override holds
      CAL_START <= cal_pulse_r & ~calovr_r[`FSCR_CALOVR_BIT];
      FINE_OFFSET <= ofs_r;
    end
  end
endmodule

// ==== verification/fscr_host.sv ====
`timescale 1ns/10ps
module fscr_host (
  input wire CORE_CLK,
  input wire RD_VALID,
  input wire [7:0] RD_DATA,
  output reg WR_STB = 1'b0,
  output reg RD_STB = 1'b0,
  output reg [7:0] REG_PTR = 8'h00,
  output reg [7:0] WR_DATA = 8'h00
);
  // one byte access, strobe held for exactly one sampling edge
  task acc(input w, input [7:0] p, input [7:0] v, output [7:0] r);
    begin
      @(posedge CORE_CLK);
      #1;
      REG_PTR = p;
      WR_DATA = v;
      WR_STB = w;
      RD_STB = !w;
      @(posedge CORE_CLK);
      #1;
      {WR_STB, RD_STB} = 2'b00;
      WR_DATA = ~v; // released bus shows no stale byte
      r = RD_VALID ? RD_DATA : 8'hxx;
    end
  endtask
endmodule

// ==== verification/fscr_regs_chk.sv ====
`timescale 1ns/10ps
module fscr_regs_chk (
  input wire CORE_CLK,
  input wire RESETN,
  input wire WR_STB,
  input wire RD_STB,
  input wire [7:0] REG_PTR,
  input wire [7:0] WR_DATA,
  input wire [9:0] INT_ADDR,
  input wire [2:0] POW2_CODE,
  input wire [5:0] POW2_RATIO,
  input wire [8:0] KV_X2_PPM,
  input wire CAL_ALLOWED,
  input wire CAL_START,
  input wire signed [23:0] FINE_OFFSET
);
  // page as the host last set it
  reg [1:0] pg_r;
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pg_r <= 2'h0;
    end else if (WR_STB && REG_PTR == 8'hff) begin
      pg_r <= WR_DATA[1:0];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_wr(a); WR_STB && pg_r == 2'h0 && REG_PTR == a; endsequence
  sequence s_cal; s_wr(8'h07) ##0 WR_DATA[3] && CAL_ALLOWED; endsequence
  property p_ratio; POW2_RATIO == (6'h1 << (POW2_CODE > 3'h5 ? 3'h5 : POW2_CODE)); endproperty
  property p_kv; s_wr(8'h20) |-> ##2 KV_X2_PPM == {4'h0, $past(WR_DATA[4:0], 2)} * 9'h00f;
  endproperty
  property p_calok; s_wr(8'h45) |-> ##2 CAL_ALLOWED == !$past(WR_DATA[7], 2); endproperty
  property p_ofs; s_wr(8'he9) |-> ##2 FINE_OFFSET[23:16] == $past(WR_DATA, 2); endproperty
  property p_hold; !$stable(FINE_OFFSET) |-> $past(WR_STB && REG_PTR == 8'he9, 2); endproperty
  property p_addr; WR_STB || RD_STB |=> INT_ADDR == {$past(pg_r), $past(REG_PTR)}; endproperty
  property p_cal; s_cal |-> ##2 CAL_START ##1 !CAL_START; endproperty
  property p_page; WR_STB && pg_r != 2'h0 && REG_PTR == 8'h20 |-> ##2 $stable(KV_X2_PPM);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio off");
  a_kv: assert property (p_kv) else $error("gain off");
  a_calok: assert property (p_calok) else $error("override off");
  a_ofs: assert property (p_ofs) else $error("offset top off");
  a_hold: assert property (p_hold) else $error("offset moved early");
  a_addr: assert property (p_addr) else $error("address off");
  a_cal: assert property (p_cal) else $error("cal pulse off");
  a_page: assert property (p_page) else $error("page write leaked");
endmodule

// ==== verification/fscr_regs_tb_top.sv ====
`timescale 1ns/10ps
module fscr_regs_tb_top;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  wire ws, rs, rv, byp, cal_ok, cal_st;
  wire [7:0] ptr, wd, rdd, fsg;
  wire [9:0] iad;
  wire [2:0] pc;
  wire [5:0] pr;
  wire [10:0] fbi, hsd;
  wire [31:0] fbf;
  wire [8:0] kv;
  wire signed [23:0] ofs;
  integer error_cnt = 0, tests_run = 0, cyc = 0, i, n;
  reg [31:0] rnd = 32'hfc3b;
  reg [7:0] d;
  reg [23:0] v, oe;
  reg [47:0] fb;
  fscr_regs fscr_regs_inst (.CORE_CLK(clk), .RESETN(resetn), .WR_STB(ws), .RD_STB(rs),
    .REG_PTR(ptr), .WR_DATA(wd), .RD_DATA(rdd), .RD_VALID(rv), .INT_ADDR(iad),
    .POW2_CODE(pc), .POW2_RATIO(pr), .POW2_BYPASS(byp), .FB_INT(fbi), .FB_FRAC(fbf),
    .HIGH_SPEED_DIVIDER_WORD(hsd), .KV_X2_PPM(kv), .FULL_SCALE_GAIN(fsg), .CAL_ALLOWED(cal_ok),
    .CAL_START(cal_st), .FINE_OFFSET(ofs));
  fscr_host fscr_host_inst (.CORE_CLK(clk), .RD_VALID(rv), .RD_DATA(rdd), .WR_STB(ws),
    .RD_STB(rs), .REG_PTR(ptr), .WR_DATA(wd));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [5:0] ratio_of(input [2:0] c);
    ratio_of = 6'h1 << (c > 3'h5 ? 3'h5 : c);
  endfunction
  // derived outputs trail the register store by one edge, so wait for them
  task w(input [7:0] p, input [7:0] x);
    begin
      fscr_host_inst.acc(1'b1, p, x, d);
      @(posedge clk);
      #1;
    end
  endtask
  task r(input [7:0] p);
    fscr_host_inst.acc(1'b0, p, 8'h00, d);
  endtask
  task chk(input [63:0] nm, input [42:0] e, input [42:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s exp %0h got %0h", nm, e, g);
      end
    end
  endtask
  // counts start pulses seen over four cycles
  task cal_cnt(input [1:0] e);
    integer k, c;
    begin
      c = 0;
      for (k = 0; k < 4; k = k + 1) begin
        c = c + cal_st;
        @(posedge clk);
        #1;
      end
      chk("calst", e, c);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  initial forever #10 clk = ~clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk("fbrst", 11'h064, fbi);
    chk("hsdrst", 11'h054, hsd);
    for (i = 0; i < 8; i = i + 1) begin
      w(8'h18, {1'b0, i[2:0], 4'h0});
      chk("ratio", ratio_of(i[2:0]), pr);
      chk("bypass", i == 0, byp);
    end
    // legal even divider 542 split over both registers
    w(8'h18, 8'h52);
    w(8'h17, 8'h1e);
    chk("high_speed_divider", 11'h21e, hsd);
    chk("ratio5", 6'h20, pr);
    $display("test divider done");
    for (i = 0; i < 6; i = i + 1) begin
      rnd = xs(rnd);
      fb = {5'h00, rnd[10:0] % 11'h7c2 + 11'h03c, xs(rnd)};
      for (n = 0; n < 6; n = n + 1) begin
        w(8'h1a + n[7:0], fb[8 * n +: 8]);
      end
      w(8'h20, rnd[23:16]);
      w(8'h23, rnd[31:24]);
      chk("fbint", fb[42:32], fbi);
      chk("fbfrac", fb[31:0], fbf);
      chk("kv", rnd[20:16] * 9'h00f, kv);
      chk("fsg", rnd[31:24], fsg);
    end
    $display("test random done");
    oe = 24'h000000;
    for (i = 0; i < 5; i = i + 1) begin
      rnd = xs(rnd);
      v = i == 0 ? 24'h7c88e8 : i == 1 ? 24'h837717 : {{2{rnd[22]}}, rnd[21:0]};
      w(8'he7, v[7:0]);
      w(8'he8, v[15:8]);
      chk("staged", oe, ofs[23:0]);
      w(8'he9, v[23:16]);
      oe = v;
      chk("offset", oe, ofs[23:0]);
    end
    w(8'h45, 8'h00);
    chk("calok", 1'b1, cal_ok);
    w(8'h07, 8'h08);
    cal_cnt(2'h1);
    r(8'h07);
    chk("rd07", 8'h00, d);
    w(8'h45, 8'h80);
    chk("calok", 1'b0, cal_ok);
    w(8'h07, 8'h08);
    cal_cnt(2'h0);
    $display("test offset and cal done");
    w(8'h20, 8'h0b);
    w(8'hff, 8'h01);
    w(8'h20, 8'h1f);
    chk("kvpg", 9'h0a5, kv);
    r(8'h20);
    chk("rdpg1", 8'h00, d);
    chk("addr", 10'h120, iad);
    w(8'hff, 8'h00);
    r(8'h20);
    chk("rdpg0", 8'h0b, d);
    $display("test page done");
    finish_test;
  end
endmodule
bind fscr_regs fscr_regs_chk fscr_regs_chk_inst (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .REG_PTR(REG_PTR), .WR_DATA(WR_DATA), .INT_ADDR(INT_ADDR),
  .POW2_CODE(POW2_CODE), .POW2_RATIO(POW2_RATIO), .KV_X2_PPM(KV_X2_PPM),
  .CAL_ALLOWED(CAL_ALLOWED), .CAL_START(CAL_START), .FINE_OFFSET(FINE_OFFSET));
